// *** logic/bit_manipulation_unit.sv ***
module bit_manipulation_unit (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [3:0] i_op,
	input wire logic [2:0] i_bit_imm,
	input wire logic i_bit_from_reg,
	input wire logic [7:0] i_bit_reg,
	input wire logic i_in_memory,
	input wire logic [7:0] i_reg_operand,
	input wire logic i_carry,
	input wire logic i_mem_rvalid,
	input wire logic [7:0] i_mem_rdata,
	output logic o_busy,
	output logic o_done,
	output logic o_illegal,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	output logic o_reg_wr,
	output logic [7:0] o_reg_wdata,
	output logic o_carry_wr,
	output logic o_carry,
	output logic o_zero_wr,
	output logic o_zero
);

	bmu_pkg::state_t state_q;
	bmu_pkg::state_t state_d;
	logic [3:0] op_q;
	logic [2:0] pos_q;
	logic [7:0] operand_q;
	logic carry_q;
	logic in_mem_q;

	logic [2:0] pos_sel;
	logic start_ok;
	logic start_bad;
	logic [7:0] new_byte;
	logic new_carry;
	logic new_zero;
	logic wr_operand;
	logic wr_carry;
	logic wr_zero;

	// Only the low three bits of the register matter
	assign pos_sel = i_bit_from_reg ? i_bit_reg[2:0] : i_bit_imm;

	// Register-sourced bit numbers are refused for the inverted forms,
	// so the operand is never touched by a malformed request
	assign start_bad = (state_q == bmu_pkg::st_idle) && i_start
		&& (!bmu_pkg::is_legal(i_op)
		|| (i_bit_from_reg && bmu_pkg::is_inverted(i_op)));
	assign start_ok = (state_q == bmu_pkg::st_idle) && i_start && !start_bad;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bmu_pkg::st_idle: begin
				if (start_ok) begin
					state_d = i_in_memory ? bmu_pkg::st_fetch : bmu_pkg::st_exec;
				end
			end
			bmu_pkg::st_fetch: begin
				if (i_mem_rvalid) begin
					state_d = bmu_pkg::st_exec;
				end
			end
			bmu_pkg::st_exec: begin
				state_d = bmu_pkg::st_idle;
			end
			default: begin
				state_d = bmu_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= bmu_pkg::st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	// Operands are frozen at the start so a changing register file or
	// carry during a memory wait cannot corrupt the result
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			op_q <= 4'h0;
			pos_q <= bmu_pkg::POS_RST;
			carry_q <= bmu_pkg::CARRY_RST;
			in_mem_q <= 1'h0;
		end else if (start_ok) begin
			op_q <= i_op;
			pos_q <= pos_sel;
			carry_q <= i_carry;
			in_mem_q <= i_in_memory;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			operand_q <= bmu_pkg::OPERAND_RST;
		end else if (start_ok && !i_in_memory) begin
			operand_q <= i_reg_operand;
		end else if (state_q == bmu_pkg::st_fetch && i_mem_rvalid) begin
			operand_q <= i_mem_rdata;
		end
	end

	bit_logic_unit u_logic (
		.i_op(op_q),
		.i_operand(operand_q),
		.i_pos(pos_q),
		.i_carry(carry_q),
		.o_byte(new_byte),
		.o_carry(new_carry),
		.o_zero(new_zero),
		.o_wr_operand(wr_operand),
		.o_wr_carry(wr_carry),
		.o_wr_zero(wr_zero)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_mem_rd <= 1'h0;
			o_busy <= 1'h0;
		end else begin
			o_mem_rd <= start_ok && i_in_memory;
			o_busy <= state_d != bmu_pkg::st_idle;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_done <= 1'h0;
			o_illegal <= 1'h0;
		end else begin
			o_done <= (state_q == bmu_pkg::st_exec) || start_bad;
			o_illegal <= start_bad;
		end
	end

	// The whole byte goes back, with only the chosen bit changed
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_mem_wr <= 1'h0;
			o_reg_wr <= 1'h0;
			o_mem_wdata <= bmu_pkg::OPERAND_RST;
			o_reg_wdata <= bmu_pkg::OPERAND_RST;
		end else begin
			o_mem_wr <= 1'h0;
			o_reg_wr <= 1'h0;
			if (state_q == bmu_pkg::st_exec && wr_operand) begin
				if (in_mem_q) begin
					o_mem_wr <= 1'h1;
					o_mem_wdata <= new_byte;
				end else begin
					o_reg_wr <= 1'h1;
					o_reg_wdata <= new_byte;
				end
			end
		end
	end

	// Flag outputs hold their last value between updates
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_carry_wr <= 1'h0;
			o_zero_wr <= 1'h0;
			o_carry <= bmu_pkg::CARRY_RST;
			o_zero <= 1'h0;
		end else begin
			o_carry_wr <= (state_q == bmu_pkg::st_exec) && wr_carry;
			o_zero_wr <= (state_q == bmu_pkg::st_exec) && wr_zero;
			if (state_q == bmu_pkg::st_exec && wr_carry) begin
				o_carry <= new_carry;
			end
			if (state_q == bmu_pkg::st_exec && wr_zero) begin
				o_zero <= new_zero;
			end
		end
	end

	// Checks
	logic exec;
	logic sel_bit;
	logic [7:0] sel_mask;
	assign exec = state_q == bmu_pkg::st_exec;
	assign sel_bit = operand_q[pos_q];
	assign sel_mask = bmu_pkg::bit_mask(pos_q);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_exec_reg(logic [3:0] op);
		exec && !in_mem_q && op_q == op;
	endsequence

	sequence s_exec_op(logic [3:0] op);
		exec && op_q == op;
	endsequence

	property p_pos_select;
		start_ok |=> pos_q == ($past(i_bit_from_reg) ? $past(i_bit_reg[2:0]) : $past(i_bit_imm));
	endproperty
	a_pos_select: assert property (p_pos_select) else $error("bit number not taken");

	property p_set;
		s_exec_reg(bmu_pkg::bit_set_op)
		|=> o_reg_wr && o_reg_wdata == ($past(operand_q) | $past(sel_mask));
	endproperty
	a_set: assert property (p_set) else $error("set result wrong");

	property p_clear;
		s_exec_reg(bmu_pkg::bit_clear_op)
		|=> o_reg_wr && o_reg_wdata == ($past(operand_q) & ~$past(sel_mask));
	endproperty
	a_clear: assert property (p_clear) else $error("clear result wrong");

	property p_invert;
		s_exec_reg(bmu_pkg::bit_invert_op)
		|=> o_reg_wr && o_reg_wdata == ($past(operand_q) ^ $past(sel_mask));
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_test;
		s_exec_op(bmu_pkg::bit_test_op)
		|=> o_zero_wr && o_zero == !$past(sel_bit) && !o_reg_wr && !o_mem_wr;
	endproperty
	a_test: assert property (p_test) else $error("test flag wrong");

	property p_and;
		s_exec_op(bmu_pkg::carry_and_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) & $past(sel_bit));
	endproperty
	a_and: assert property (p_and) else $error("carry and wrong");

	property p_and_inv;
		s_exec_op(bmu_pkg::carry_and_inverted_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) & !$past(sel_bit));
	endproperty
	a_and_inv: assert property (p_and_inv) else $error("carry and-not wrong");

	property p_or;
		s_exec_op(bmu_pkg::carry_or_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) | $past(sel_bit));
	endproperty
	a_or: assert property (p_or) else $error("carry or wrong");

	property p_or_inv;
		s_exec_op(bmu_pkg::carry_or_inverted_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) | !$past(sel_bit));
	endproperty
	a_or_inv: assert property (p_or_inv) else $error("carry or-not wrong");

	property p_xor;
		s_exec_op(bmu_pkg::carry_xor_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) ^ $past(sel_bit));
	endproperty
	a_xor: assert property (p_xor) else $error("carry xor wrong");

	property p_xor_inv;
		s_exec_op(bmu_pkg::carry_xor_inverted_bit_op)
		|=> o_carry_wr && o_carry == ($past(carry_q) ^ !$past(sel_bit));
	endproperty
	a_xor_inv: assert property (p_xor_inv) else $error("carry xor-not wrong");

	property p_load;
		s_exec_op(bmu_pkg::load_bit_to_carry_op)
		|=> o_carry_wr && o_carry == $past(sel_bit) && !o_reg_wr && !o_mem_wr;
	endproperty
	a_load: assert property (p_load) else $error("load to carry wrong");

	property p_load_inv;
		s_exec_op(bmu_pkg::load_inverted_bit_to_carry_op)
		|=> o_carry_wr && o_carry == !$past(sel_bit) && !o_reg_wr && !o_mem_wr;
	endproperty
	a_load_inv: assert property (p_load_inv) else $error("inverted load wrong");

	property p_store;
		s_exec_reg(bmu_pkg::store_carry_to_bit_op)
		|=> o_reg_wr && o_reg_wdata[$past(pos_q)] == $past(carry_q)
		&& (o_reg_wdata & ~$past(sel_mask)) == ($past(operand_q) & ~$past(sel_mask));
	endproperty
	a_store: assert property (p_store) else $error("store carry wrong");

	property p_store_inv;
		s_exec_reg(bmu_pkg::store_inverted_carry_to_bit_op)
		|=> o_reg_wr && o_reg_wdata[$past(pos_q)] == !$past(carry_q)
		&& (o_reg_wdata & ~$past(sel_mask)) == ($past(operand_q) & ~$past(sel_mask));
	endproperty
	a_store_inv: assert property (p_store_inv) else $error("inverted store wrong");

	property p_inv_reject;
		state_q == bmu_pkg::st_idle && i_start && i_bit_from_reg
		&& bmu_pkg::is_inverted(i_op)
		|=> o_illegal && o_done && !o_busy && !o_mem_rd ##1 !o_reg_wr && !o_carry_wr;
	endproperty
	a_inv_reject: assert property (p_inv_reject) else $error("register bit not refused");

	sequence s_mem_fetch;
		state_q == bmu_pkg::st_fetch && i_mem_rvalid && bmu_pkg::writes_operand(op_q);
	endsequence

	sequence s_mem_write;
		exec ##1 o_mem_wr && !o_reg_wr
		&& (o_mem_wdata & ~sel_mask) == ($past(i_mem_rdata, 2) & ~sel_mask);
	endsequence

	property p_mem_rmw;
		s_mem_fetch |=> s_mem_write;
	endproperty
	a_mem_rmw: assert property (p_mem_rmw) else $error("memory byte not preserved");

	property p_mem_read;
		start_ok && i_in_memory |=> o_mem_rd && !o_mem_wr ##1 !o_mem_rd;
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("memory read missing");

endmodule

// *** logic/bmu_pkg.sv ***
package bmu_pkg;

	localparam int BYTE_W = 8;
	localparam int POS_W = 3;

	localparam logic [7:0] OPERAND_RST = 8'h00;
	localparam logic [2:0] POS_RST = 3'h0;
	localparam logic CARRY_RST = 1'h0;
	localparam logic [7:0] ONE_HOT_BASE = 8'h01;

	typedef enum logic [3:0] {
		bit_set_op = 4'h0,
		bit_clear_op = 4'h1,
		bit_invert_op = 4'h2,
		bit_test_op = 4'h3,
		carry_and_bit_op = 4'h4,
		carry_and_inverted_bit_op = 4'h5,
		carry_or_bit_op = 4'h6,
		carry_or_inverted_bit_op = 4'h7,
		carry_xor_bit_op = 4'h8,
		carry_xor_inverted_bit_op = 4'h9,
		load_bit_to_carry_op = 4'ha,
		load_inverted_bit_to_carry_op = 4'hb,
		store_carry_to_bit_op = 4'hc,
		store_inverted_carry_to_bit_op = 4'hd
	} bit_op_t;

	localparam logic [3:0] LAST_OP_CODE = 4'hd;

	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_fetch = 2'h1,
		st_exec = 2'h2
	} state_t;

	function automatic logic [7:0] bit_mask(input logic [2:0] pos);
		return ONE_HOT_BASE << pos;
	endfunction

	function automatic logic is_legal(input logic [3:0] code);
		return code <= LAST_OP_CODE;
	endfunction

	function automatic logic is_inverted(input logic [3:0] code);
		return code inside {carry_and_inverted_bit_op, carry_or_inverted_bit_op,
			carry_xor_inverted_bit_op, load_inverted_bit_to_carry_op,
			store_inverted_carry_to_bit_op};
	endfunction

	function automatic logic writes_operand(input logic [3:0] code);
		return code inside {bit_set_op, bit_clear_op, bit_invert_op,
			store_carry_to_bit_op, store_inverted_carry_to_bit_op};
	endfunction

endpackage

// *** logic/bit_logic_unit.sv ***
module bit_logic_unit (
	input wire logic [3:0] i_op,
	input wire logic [7:0] i_operand,
	input wire logic [2:0] i_pos,
	input wire logic i_carry,
	output logic [7:0] o_byte,
	output logic o_carry,
	output logic o_zero,
	output logic o_wr_operand,
	output logic o_wr_carry,
	output logic o_wr_zero
);

	logic sel;
	logic [7:0] mask;

	always_comb begin
		sel = i_operand[i_pos];
		mask = bmu_pkg::bit_mask(i_pos);
		o_byte = i_operand;
		o_carry = i_carry;
		o_zero = 1'h0;
		o_wr_operand = 1'h0;
		o_wr_carry = 1'h0;
		o_wr_zero = 1'h0;
		unique case (i_op)
			bmu_pkg::bit_set_op: begin
				o_byte = i_operand | mask;
				o_wr_operand = 1'h1;
			end
			bmu_pkg::bit_clear_op: begin
				o_byte = i_operand & ~mask;
				o_wr_operand = 1'h1;
			end
			bmu_pkg::bit_invert_op: begin
				o_byte = i_operand ^ mask;
				o_wr_operand = 1'h1;
			end
			bmu_pkg::bit_test_op: begin
				o_zero = ~sel;
				o_wr_zero = 1'h1;
			end
			bmu_pkg::carry_and_bit_op: begin
				o_carry = i_carry & sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::carry_and_inverted_bit_op: begin
				o_carry = i_carry & ~sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::carry_or_bit_op: begin
				o_carry = i_carry | sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::carry_or_inverted_bit_op: begin
				o_carry = i_carry | ~sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::carry_xor_bit_op: begin
				o_carry = i_carry ^ sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::carry_xor_inverted_bit_op: begin
				o_carry = i_carry ^ ~sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::load_bit_to_carry_op: begin
				o_carry = sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::load_inverted_bit_to_carry_op: begin
				o_carry = ~sel;
				o_wr_carry = 1'h1;
			end
			bmu_pkg::store_carry_to_bit_op: begin
				o_byte = (i_operand & ~mask) | (i_carry ? mask : 8'h00);
				o_wr_operand = 1'h1;
			end
			bmu_pkg::store_inverted_carry_to_bit_op: begin
				o_byte = (i_operand & ~mask) | (i_carry ? 8'h00 : mask);
				o_wr_operand = 1'h1;
			end
			default: begin
				o_byte = i_operand;
			end
		endcase
	end

endmodule

// *** bench/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_clk;
	logic i_rst_n;
	logic i_start;
	logic [3:0] i_op;
	logic [2:0] i_bit_imm;
	logic i_bit_from_reg;
	logic [7:0] i_bit_reg;
	logic i_in_memory;
	logic [7:0] i_reg_operand;
	logic i_carry;
	logic i_mem_rvalid;
	logic [7:0] i_mem_rdata;
	logic o_busy, o_done, o_illegal, o_mem_rd, o_mem_wr, o_reg_wr;
	logic o_carry_wr, o_carry, o_zero_wr, o_zero;
	logic [7:0] o_mem_wdata, o_reg_wdata;
	int errors = 0;
	int checks_done = 0;

	bit_manipulation_unit dut (
		.i_clk,
		.i_rst_n,
		.i_start,
		.i_op,
		.i_bit_imm,
		.i_bit_from_reg,
		.i_bit_reg,
		.i_in_memory,
		.i_reg_operand,
		.i_carry,
		.i_mem_rvalid,
		.i_mem_rdata,
		.o_busy,
		.o_done,
		.o_illegal,
		.o_mem_rd,
		.o_mem_wr,
		.o_mem_wdata,
		.o_reg_wr,
		.o_reg_wdata,
		.o_carry_wr,
		.o_carry,
		.o_zero_wr,
		.o_zero
	);

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Reference behaviour of one request, worked out independently of the design
	function automatic void model(input logic [3:0] op, input logic [2:0] p,
		input logic [7:0] v, input logic c, output logic [7:0] nb, output logic wb,
		output logic nc, output logic wc);
		logic b;
		b = v[p];
		nb = v;
		nc = c;
		wb = 1'b1;
		wc = (op >= 4'h4 && op <= 4'hb);
		case (op)
			4'h0: nb[p] = 1'b1;
			4'h1: nb[p] = 1'b0;
			4'h2: nb[p] = ~b;
			4'hc: nb[p] = c;
			4'hd: nb[p] = ~c;
			default: wb = 1'b0;
		endcase
		case (op)
			4'h4: nc = c & b;
			4'h5: nc = c & ~b;
			4'h6: nc = c | b;
			4'h7: nc = c | ~b;
			4'h8: nc = c ^ b;
			4'h9: nc = c ^ ~b;
			4'ha: nc = b;
			4'hb: nc = ~b;
			default: ;
		endcase
	endfunction

	// Issues one request, plays memory if asked, collects every pulse up to done
	task automatic do_op(input logic [3:0] op, input logic [2:0] imm, input logic frm,
		input logic [7:0] breg, input logic mem, input logic [7:0] v, input logic c);
		logic [7:0] nb, wdat;
		logic wb, nc, wc, wz, ill, dn, gi, rd, rw, mw, cw, zw, gc, gz, bz;
		logic [2:0] p;
		int n;
		p = frm ? breg[2:0] : imm;
		ill = (op > 4'hd) || (frm && op[0] && op > 4'h4);
		model(op, p, v, c, nb, wb, nc, wc);
		wz = (op == 4'h3) && !ill;
		wb = wb && !ill;
		wc = wc && !ill;
		{dn, gi, rd, rw, mw, cw, zw, gc, gz, bz} = '0;
		wdat = 8'h00;
		@(negedge i_clk);
		i_start = 1'b1;
		i_op = op;
		i_bit_imm = imm;
		i_bit_from_reg = frm;
		i_bit_reg = breg;
		i_in_memory = mem;
		// A memory operand must come from the bus, so the register port shows a decoy
		i_reg_operand = mem ? ~v : v;
		i_carry = c;
		@(negedge i_clk);
		i_start = 1'b0;
		i_reg_operand = ~v;
		i_carry = ~c;
		for (n = 0; n < 12 && dn !== 1'b1; n++) begin
			rd = rd | (o_mem_rd === 1'b1);
			i_mem_rvalid = (o_mem_rd === 1'b1);
			i_mem_rdata = (o_mem_rd === 1'b1) ? v : ~v;
			if (o_reg_wr === 1'b1) begin
				rw = 1'b1;
				wdat = o_reg_wdata;
			end
			if (o_mem_wr === 1'b1) begin
				mw = 1'b1;
				wdat = o_mem_wdata;
			end
			if (o_carry_wr === 1'b1) begin
				cw = 1'b1;
				gc = o_carry;
			end
			if (o_zero_wr === 1'b1) begin
				zw = 1'b1;
				gz = o_zero;
			end
			// Busy must rise with a legal start and stay low for a refused one
			if (n == 0)
				bz = o_busy;
			gi = o_illegal;
			dn = o_done;
			if (dn !== 1'b1)
				@(negedge i_clk);
		end
		if (dn !== 1'b1) begin
			errors++;
			$display("BAD done expected 1 seen %b", dn);
			summarize();
		end
		chk("illegal", 8'(ill), 8'(gi));
		chk("busy", 8'(!ill), 8'(bz));
		chk("busy end", 8'h00, 8'(o_busy));
		chk("mem_rd", 8'(mem && !ill), 8'(rd));
		chk("reg_wr", 8'(wb && !mem), 8'(rw));
		chk("mem_wr", 8'(wb && mem), 8'(mw));
		if (wb)
			chk("write data", nb, wdat);
		chk("carry_wr", 8'(wc), 8'(cw));
		if (wc)
			chk("carry", 8'(nc), 8'(gc));
		chk("zero_wr", 8'(wz), 8'(zw));
		if (wz)
			chk("zero", 8'(!v[p]), 8'(gz));
	endtask

	task automatic t_reset;
		chk("idle strobes", 8'h00, {o_busy, o_done, o_illegal, o_mem_rd, o_mem_wr, o_reg_wr,
			o_carry_wr, o_zero_wr});
		chk("idle data", 8'h00, o_reg_wdata | o_mem_wdata);
		chk("idle flags", 8'h00, {6'h00, o_carry, o_zero});
		$display("test reset done");
	endtask

	task automatic t_modify_reg;
		for (int p = 0; p < 8; p++) begin
			do_op(4'h0, 3'(p), 1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
			do_op(4'h1, 3'(7 - p), 1'b1, 8'(8'hf8 | p), 1'b0, 8'hff, 1'b1);
			do_op(4'h2, 3'(p), 1'b0, 8'h00, 1'b0, 8'h5a, 1'b0);
			do_op(4'hc, 3'(7 - p), 1'b1, 8'(p), 1'b0, 8'h0f, p[0]);
			do_op(4'hd, 3'(p), 1'b0, 8'h00, 1'b0, 8'hf0, p[1]);
		end
		$display("test modify_reg done");
	endtask

	task automatic t_flag_ops;
		for (int k = 0; k < 4; k++) begin
			do_op(4'h3, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h4, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h5, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h6, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h7, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h8, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'h9, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'ha, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
			do_op(4'hb, 3'h5, 1'h0, 8'h00, 1'h0, k[0] ? 8'h20 : 8'hdf, k[1]);
		end
		do_op(4'h4, 3'h2, 1'b1, 8'hed, 1'b0, 8'h20, 1'b1);
		do_op(4'h3, 3'h0, 1'b1, 8'h7e, 1'b0, 8'hbf, 1'b0);
		$display("test flag_ops done");
	endtask

	task automatic t_memory;
		do_op(4'h0, 3'h7, 1'b0, 8'h00, 1'b1, 8'h3c, 1'b0);
		do_op(4'h1, 3'h6, 1'b0, 8'h00, 1'b1, 8'hff, 1'b0);
		do_op(4'h2, 3'h0, 1'b1, 8'h02, 1'b1, 8'ha5, 1'b0);
		do_op(4'hc, 3'h2, 1'b0, 8'h00, 1'b1, 8'h00, 1'b1);
		do_op(4'hd, 3'h3, 1'b0, 8'h00, 1'b1, 8'hff, 1'b0);
		do_op(4'h3, 3'h4, 1'b0, 8'h00, 1'b1, 8'hef, 1'b0);
		do_op(4'hb, 3'h1, 1'b0, 8'h00, 1'b1, 8'h02, 1'b0);
		$display("test memory done");
	endtask

	task automatic t_refused;
		for (int op = 5; op < 14; op += 2) begin
			do_op(4'(op), 3'h1, 1'b1, 8'h01, 1'b0, 8'h02, 1'b1);
		end
		do_op(4'hb, 3'h1, 1'b1, 8'h01, 1'b1, 8'h02, 1'b1);
		do_op(4'he, 3'h1, 1'b0, 8'h00, 1'b0, 8'h02, 1'b1);
		do_op(4'hf, 3'h1, 1'b0, 8'h00, 1'b1, 8'h02, 1'b1);
		do_op(4'h7, 3'h1, 1'b0, 8'h00, 1'b0, 8'h02, 1'b0);
		$display("test refused done");
	endtask

	// Reset lands while a memory fetch is pending; the block must come back idle
	task automatic t_mid_reset;
		@(negedge i_clk);
		i_start = 1'h1;
		i_op = 4'h0;
		i_bit_from_reg = 1'h0;
		i_in_memory = 1'h1;
		@(negedge i_clk);
		i_start = 1'h0;
		chk("fetch read", 8'h01, 8'(o_mem_rd));
		i_rst_n = 1'h0;
		@(negedge i_clk);
		i_rst_n = 1'h1;
		t_reset();
		do_op(4'h2, 3'h6, 1'h0, 8'h00, 1'h1, 8'h41, 1'h1);
		$display("test mid_reset done");
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_start = 1'b0;
		i_op = 4'h0;
		i_bit_imm = 3'h0;
		i_bit_from_reg = 1'b0;
		i_bit_reg = 8'h00;
		i_in_memory = 1'b0;
		i_reg_operand = 8'h00;
		i_carry = 1'b0;
		i_mem_rvalid = 1'b0;
		i_mem_rdata = 8'h00;
		repeat (12) @(negedge i_clk);
		i_rst_n = 1'b1;
		t_reset();
		t_modify_reg();
		t_flag_ops();
		t_memory();
		t_refused();
		t_mid_reset();
		summarize();
	end
endmodule
